// [hw/dbgm_pkg.sv]
/*
 * Package for the debug port pin multiplexer: routing modes, idle levels
 * driven into the unselected function, status layout and the default
 * settle count.
 * Assumes nothing beyond a SystemVerilog compiler; no timescale here.
 */
package dbgm_pkg;

	// Pin select level chooses the routing; one bit, trivially Gray
	typedef enum logic {
		DBGM_MODE_UART = 1'h0,
		DBGM_MODE_JTAG = 1'h1
	} dbgm_mode_t;

	localparam dbgm_mode_t DBGM_RST_MODE = DBGM_MODE_UART;

	// Output enable levels
	localparam logic DBGM_DRIVE_ON  = 1'h1;
	localparam logic DBGM_DRIVE_OFF = 1'h0;

	// Levels fed to the function that is not selected, and the level on an undriven pin output
	localparam logic DBGM_IDLE_TCK    = 1'h0;
	localparam logic DBGM_IDLE_TMS    = 1'h1;
	localparam logic DBGM_IDLE_TDI    = 1'h1;
	localparam logic DBGM_IDLE_TRST_N = 1'h0;
	localparam logic DBGM_IDLE_RX     = 1'h1;
	localparam logic DBGM_IDLE_BOOT   = 1'h0;
	localparam logic DBGM_IDLE_VCTL   = 1'h0;
	localparam logic DBGM_IDLE_PIN    = 1'h0;

	// Status reset values
	localparam logic DBGM_RST_SETTLED = 1'h0;
	localparam logic DBGM_RST_CHANGED = 1'h0;

	// Cycles the select level must hold before the mode counts as settled
	localparam int unsigned DBGM_SETTLE_DEFAULT = 8;

	// Inputs of the boundary-scan logic
	typedef struct packed {
		logic tck;
		logic tdi;
		logic tms;
		logic trst_n;
	} dbgm_scan_in_t;

	// Outputs of the boundary-scan logic
	typedef struct packed {
		logic tdo;
		logic tdo_oe;
	} dbgm_scan_out_t;

	// Inputs of the UART, boot and vendor functions
	typedef struct packed {
		logic rx;
		logic boot;
		logic vendor_ctl_i;
	} dbgm_uart_in_t;

	// Outputs of the UART and vendor functions
	typedef struct packed {
		logic tx;
		logic vendor_ctl_o;
		logic vendor_ctl_oe;
	} dbgm_uart_out_t;

	// Registered view of the routing
	typedef struct packed {
		dbgm_mode_t mode;
		logic       settled;
		logic       changed;
	} dbgm_status_t;

endpackage

// [hw/dbgm_pin_mux.sv]
/*
 * Debug port pin multiplexer: steers five debug pins between the
 * boundary-scan port and the UART, boot and vendor control functions,
 * and keeps a registered status of the current routing.
 * Assumes pin inputs synchronous to clock, the wire level resolved
 * outside from the output enables, and scan and UART logic on the core
 * side of the struct ports.
 */
`timescale 1ns/10ps
`default_nettype none

// What this block does
// R01: Pin one carries scan clock or vendor control
// R02: Pin two drives scan data out or TX
// R03: Pin three feeds scan data in or RX
// R04: Pin four feeds scan mode select or boot
// R05: Pin five is scan reset or mux select
// R06: Select high routes scan, low routes UART
// R07: Carrier never drives or pulls debug pins
// R08: Routing combinational; unselected outputs stay undriven
module dbgm_pin_mux #(
	parameter int unsigned SETTLE_CYCLES = dbgm_pkg::DBGM_SETTLE_DEFAULT
) (
	input  wire logic                     clock,
	input  wire logic                     rst_n,
	input  wire logic                     clk_en,
	input  wire logic                     debug_pin_clock_ctl_i,
	output logic                          debug_pin_clock_ctl_o,
	output logic                          debug_pin_clock_ctl_oe,
	output logic                          debug_pin_out_tx_o,
	output logic                          debug_pin_out_tx_oe,
	input  wire logic                     debug_pin_in_rx_i,
	input  wire logic                     debug_pin_mode_boot_i,
	input  wire logic                     debug_pin_select_i,
	input  wire dbgm_pkg::dbgm_scan_out_t scan_out,
	output dbgm_pkg::dbgm_scan_in_t       scan_in,
	input  wire dbgm_pkg::dbgm_uart_out_t uart_out,
	output dbgm_pkg::dbgm_uart_in_t       uart_in,
	output dbgm_pkg::dbgm_status_t        status
);
	import dbgm_pkg::*;

	localparam int unsigned CNT_W = $clog2(SETTLE_CYCLES + 1);
	localparam logic [CNT_W-1:0] SETTLE_CNT = CNT_W'(SETTLE_CYCLES);
	localparam logic [CNT_W-1:0] CNT_ZERO   = '0;
	localparam logic [CNT_W-1:0] CNT_ONE    = CNT_W'(1);

	// Decodes the select pin level into a routing mode
	function automatic dbgm_mode_t decode_mode(input logic sel);
		begin
			decode_mode = sel ? DBGM_MODE_JTAG : DBGM_MODE_UART;
		end
	endfunction

	dbgm_mode_t       pin_mode;
	dbgm_mode_t       mode_ff;
	logic             changed_ff;
	logic [CNT_W-1:0] settle_cnt_ff;
	logic             mode_moved;

	// Mode follows the pin with no register in the path
	assign pin_mode   = decode_mode(debug_pin_select_i); // see R06
	assign mode_moved = (pin_mode != mode_ff);

	// Pin one: scan clock in, or vendor control in both directions
	always_comb begin
		debug_pin_clock_ctl_o  = DBGM_IDLE_PIN;
		debug_pin_clock_ctl_oe = DBGM_DRIVE_OFF;
		unique case (pin_mode)
			DBGM_MODE_JTAG: begin
				// Scan clock is an input only
				debug_pin_clock_ctl_o  = DBGM_IDLE_PIN; // see R08
				debug_pin_clock_ctl_oe = DBGM_DRIVE_OFF; // see R01
			end
			DBGM_MODE_UART: begin
				debug_pin_clock_ctl_o  = uart_out.vendor_ctl_o; // see R01
				debug_pin_clock_ctl_oe = uart_out.vendor_ctl_oe; // see R01
			end
		endcase
	end

	// Pin two: scan data out, or serial transmit
	always_comb begin
		debug_pin_out_tx_o  = DBGM_IDLE_PIN;
		debug_pin_out_tx_oe = DBGM_DRIVE_OFF;
		unique case (pin_mode)
			DBGM_MODE_JTAG: begin
				// Scan logic decides when data out is driven
				debug_pin_out_tx_o  = scan_out.tdo; // see R02
				debug_pin_out_tx_oe = scan_out.tdo_oe; // see R08
			end
			DBGM_MODE_UART: begin
				debug_pin_out_tx_o  = uart_out.tx; // see R02
				debug_pin_out_tx_oe = DBGM_DRIVE_ON; // see R02
			end
		endcase
	end

	// Scan inputs: live pins in scan mode, idle levels otherwise
	always_comb begin
		scan_in.tck    = DBGM_IDLE_TCK;
		scan_in.tdi    = DBGM_IDLE_TDI;
		scan_in.tms    = DBGM_IDLE_TMS;
		scan_in.trst_n = DBGM_IDLE_TRST_N;
		unique case (pin_mode)
			DBGM_MODE_JTAG: begin
				scan_in.tck    = debug_pin_clock_ctl_i; // see R01
				scan_in.tdi    = debug_pin_in_rx_i; // see R03
				scan_in.tms    = debug_pin_mode_boot_i; // see R04
				// Select pin doubles as the active-low scan reset
				scan_in.trst_n = debug_pin_select_i; // see R05
			end
			DBGM_MODE_UART: begin
				// Scan logic held in reset while the pins serve the UART
				scan_in.tck    = DBGM_IDLE_TCK; // see R06
				scan_in.tdi    = DBGM_IDLE_TDI; // see R06
				scan_in.tms    = DBGM_IDLE_TMS; // see R06
				scan_in.trst_n = DBGM_IDLE_TRST_N; // see R05
			end
		endcase
	end

	// UART, boot and vendor inputs: live pins in UART mode only
	always_comb begin
		uart_in.rx           = DBGM_IDLE_RX;
		uart_in.boot         = DBGM_IDLE_BOOT;
		uart_in.vendor_ctl_i = DBGM_IDLE_VCTL;
		unique case (pin_mode)
			DBGM_MODE_JTAG: begin
				// Idle line levels so the UART sees no false start bit
				uart_in.rx           = DBGM_IDLE_RX; // see R06
				uart_in.boot         = DBGM_IDLE_BOOT; // see R06
				uart_in.vendor_ctl_i = DBGM_IDLE_VCTL; // see R06
			end
			DBGM_MODE_UART: begin
				// Pins are read bare: no keeper, the tool sets the level
				uart_in.rx           = debug_pin_in_rx_i; // see R03 R07
				uart_in.boot         = debug_pin_mode_boot_i; // see R04
				uart_in.vendor_ctl_i = debug_pin_clock_ctl_i; // see R01
			end
		endcase
	end

	// Registered copy of the routing mode
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			mode_ff <= DBGM_RST_MODE;
		end else if (clk_en) begin
			mode_ff <= pin_mode; // see R05
		end
	end

	// One-cycle pulse whenever the select level has moved
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			changed_ff <= DBGM_RST_CHANGED;
		end else if (clk_en) begin
			changed_ff <= mode_moved;
		end
	end

	// Counts enabled cycles since the last move, saturating
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			settle_cnt_ff <= CNT_ZERO;
		end else if (clk_en) begin
			if (mode_moved) begin
				settle_cnt_ff <= CNT_ZERO;
			end else if (settle_cnt_ff != SETTLE_CNT) begin
				settle_cnt_ff <= settle_cnt_ff + CNT_ONE;
			end
		end
	end

	assign status.mode    = mode_ff;
	assign status.changed = changed_ff;
	assign status.settled = (settle_cnt_ff == SETTLE_CNT);

endmodule

`default_nettype wire

// [dv/dbgm_pin_mux_checker.sv]
/* Assertions on pin routing and status of the debug pin multiplexer.
   Assumes the bind below attaches it to every instance. */
`timescale 1ns/10ps
`default_nettype none
module dbgm_pin_mux_chk
	import dbgm_pkg::*;
(
	input wire logic           clock,
	input wire logic           rst_n,
	input wire logic           clk_en,
	input wire logic           debug_pin_clock_ctl_i,
	input wire logic           debug_pin_clock_ctl_o,
	input wire logic           debug_pin_clock_ctl_oe,
	input wire logic           debug_pin_out_tx_o,
	input wire logic           debug_pin_out_tx_oe,
	input wire logic           debug_pin_in_rx_i,
	input wire logic           debug_pin_mode_boot_i,
	input wire logic           debug_pin_select_i,
	input wire dbgm_scan_out_t scan_out,
	input wire dbgm_scan_in_t  scan_in,
	input wire dbgm_uart_out_t uart_out,
	input wire dbgm_uart_in_t  uart_in,
	input wire dbgm_status_t   status
);
	default clocking @(posedge clock); endclocking
	default disable iff (!rst_n);
	wire logic sel = debug_pin_select_i;
	scan_tx_a: assert property (sel |->
		debug_pin_out_tx_o == scan_out.tdo &&
		debug_pin_out_tx_oe == scan_out.tdo_oe) else $error("pin two not tdo");
	uart_tx_a: assert property (!sel |->
		debug_pin_out_tx_o == uart_out.tx && debug_pin_out_tx_oe)
		else $error("pin two not tx");
	pin1_scan_a: assert property (sel |-> !debug_pin_clock_ctl_oe)
		else $error("pin one driven in scan mode");
	pin1_vendor_a: assert property (!sel |->
		debug_pin_clock_ctl_o == uart_out.vendor_ctl_o &&
		debug_pin_clock_ctl_oe == uart_out.vendor_ctl_oe)
		else $error("pin one not vendor control");
	scan_in_a: assert property (sel |->
		scan_in == {debug_pin_clock_ctl_i, debug_pin_in_rx_i,
		debug_pin_mode_boot_i, 1'h1} && !uart_in.boot && uart_in.rx)
		else $error("scan inputs misrouted");
	uart_in_a: assert property (!sel |->
		uart_in == {debug_pin_in_rx_i, debug_pin_mode_boot_i,
		debug_pin_clock_ctl_i} && !scan_in.trst_n && !scan_in.tck)
		else $error("uart inputs misrouted");
	mode_follow_a: assert property (clk_en |=>
		status.mode == $past(sel)) else $error("mode lost select");
	change_pulse_a: assert property (clk_en && sel != status.mode
		|=> status.changed) else $error("no change pulse");
	status_hold_a: assert property (!clk_en |=> $stable(status))
		else $error("status moved while frozen");
endmodule
bind dbgm_pin_mux dbgm_pin_mux_chk u_chk (.*);
`default_nettype wire

// [dv/dbgm_tool_model.sv]
/* Debug connector tool on pin one.
   Assumes the bench gives the level the tool wants to send. */
`timescale 1ns/10ps
`default_nettype none
module dbgm_tool_model (
	input  wire logic tool,
	input  wire logic dev,
	input  wire logic dev_oe,
	output logic      pin
);
	// No pulls; the tool yields while the module drives
	assign pin = dev_oe ? dev : tool;
endmodule
`default_nettype wire

// [dv/dbgm_pin_mux_tb.sv]
/* Random routing bench for the debug pin multiplexer.
   Assumes the checker file binds its assertions. */
`timescale 1ns/10ps
`default_nettype none
module dbgm_pin_mux_tb;
	import dbgm_pkg::*;
	logic clock = 1'h0, rst_n = 1'h0, clk_en = 1'h0, sel = 1'h0;
	logic tck = 1'h0, rx = 1'h1, boot = 1'h0, p1, c_o, c_oe, t_o, t_oe, lv;
	dbgm_scan_out_t so = '0;
	dbgm_uart_out_t uo = '0;
	dbgm_scan_in_t  si;
	dbgm_uart_in_t  ui;
	dbgm_status_t   st;
	logic           em = 1'h0, ec = 1'h0;
	int             ecnt = 0;
	logic [10:0]    q[$];
	logic [10:0]    e;
	int             mismatches = 0;
	int             checks = 0;
	always #50 clock = ~clock;
	dbgm_tool_model u_dbgm_tool_model (.tool(tck), .dev(c_o), .dev_oe(c_oe),
		.pin(p1));
	dbgm_pin_mux #(.SETTLE_CYCLES(2)) u_dbgm_pin_mux (.clock(clock),
		.rst_n(rst_n), .clk_en(clk_en), .debug_pin_clock_ctl_i(p1),
		.debug_pin_clock_ctl_o(c_o), .debug_pin_clock_ctl_oe(c_oe),
		.debug_pin_out_tx_o(t_o), .debug_pin_out_tx_oe(t_oe),
		.debug_pin_in_rx_i(rx), .debug_pin_mode_boot_i(boot),
		.debug_pin_select_i(sel), .scan_out(so), .scan_in(si),
		.uart_out(uo), .uart_in(ui), .status(st));
	// Status reference: mode lags select, pulse on move, settle after 2
	always @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			em <= DBGM_RST_MODE;
			ec <= DBGM_RST_CHANGED;
			ecnt <= 0;
		end else if (clk_en) begin
			em <= sel;
			ec <= (sel != em);
			ecnt <= (sel != em) ? 0 : ((ecnt == 2) ? 2 : ecnt + 1);
		end
	end
	task step;
		@(posedge clock);
		#5;
		{sel, tck, rx, boot, clk_en, so, uo} = 10'($urandom);
		lv = (!sel && uo.vendor_ctl_oe) ? uo.vendor_ctl_o : tck;
		if (sel)
			q.push_back({lv, rx, boot, 1'h1, DBGM_IDLE_RX, DBGM_IDLE_BOOT,
				DBGM_IDLE_VCTL, so.tdo, so.tdo_oe, 2'h0});
		else
			q.push_back({DBGM_IDLE_TCK, DBGM_IDLE_TDI, DBGM_IDLE_TMS,
				DBGM_IDLE_TRST_N, rx, boot, lv, uo.tx, 1'h1, uo.vendor_ctl_o,
				uo.vendor_ctl_oe});
	endtask
	always @(negedge clock) begin
		checks++;
		if (st !== {em, ecnt == 2, ec}) begin
			mismatches++;
			$display("BAD status exp %h got %h", {em, ecnt == 2, ec}, st);
		end
		if (q.size() != 0) begin
			e = q.pop_front();
			checks++;
			if ({si, ui, t_o, t_oe, c_o, c_oe} !== e) begin
				mismatches++;
				$display("BAD routing exp %h got %h", e,
					{si, ui, t_o, t_oe, c_o, c_oe});
			end
		end
	end
	task conclude;
		@(negedge clock);
		#1;
		$display("checks %0d mismatches %0d", checks, mismatches);
		if (mismatches == 0 && checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	initial begin
		void'($urandom(32'h50fbcb70));
		repeat (10) @(posedge clock);
		#5 rst_n = 1'h1;
		repeat (400) step();
		$display("test random routing done");
		rst_n = 1'h0;
		repeat (2) step();
		rst_n = 1'h1;
		repeat (200) step();
		$display("test reset in mid run done");
		conclude();
	end
endmodule
`default_nettype wire
